// ===== pkg/pfs_pkg.sv
// Constants, types and decode helpers for the pin function selector.
// Assumes the selector and its neighbours all run on one system clock.

package pfs_pkg;

	// ****************************************
	// Pad indices
	// ****************************************
	localparam int NUM_PADS = 6;
	localparam int NUM_INS  = 7;
	localparam int PAD_A4   = 0;
	localparam int PAD_A5   = 1;
	localparam int PAD_A6   = 2;
	localparam int PAD_B1   = 3;
	localparam int PAD_B2   = 4;
	localparam int PAD_C2   = 5;
	localparam int PAD_DCLK = 6;

	// ****************************************
	// Configuration field codes
	// ****************************************
	localparam logic [3:0] CFG_ANALOG = 4'h0;
	localparam logic [3:0] CFG_ALT_PP = 4'h9;
	localparam logic [3:0] CFG_ALT_OD = 4'hd;
	localparam int REMAP_CH1 = 4;
	localparam int REMAP_CH2 = 5;

	localparam logic [1:0] SC_OFF  = 2'h0;
	localparam logic [1:0] SC_UART = 2'h1;
	localparam logic [1:0] SC_SPI  = 2'h2;
	localparam logic [1:0] SC_TWI  = 2'h3;

	// Cycles for a released pin level to clear the synchroniser
	localparam logic [1:0] BOOT_WAIT = 2'h2;

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		PFS_DBG_JTAG  = 2'b01,
		PFS_DBG_SWIRE = 2'b10
	} pfs_dbg_t;

	typedef struct packed {
		logic drive;
		logic oe_n;
		logic pull_up;
		logic analog;
	} pfs_pad_t;

	localparam pfs_pad_t PAD_IDLE = '{drive: 1'b0, oe_n: 1'b1, pull_up: 1'b0, analog: 1'b0};

	function automatic logic pfs_is_analog(input logic [3:0] cfg);
		return cfg == CFG_ANALOG;
	endfunction

	function automatic logic pfs_is_alt(input logic [3:0] cfg);
		return cfg == CFG_ALT_PP;
	endfunction

	function automatic logic pfs_is_od(input logic [3:0] cfg);
		return cfg == CFG_ALT_OD;
	endfunction

endpackage

// ===== design/pfs_sync.sv
// Two-stage synchroniser for pad levels entering the system clock.
// Assumes each bit is an independent level; no bus coherence is kept.
`timescale 1ns/1ps

module pfs_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] meta_r;
	logic [WIDTH-1:0] sync_r;

	// First stage feeds only the second stage
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= i_async;
			sync_r <= meta_r;
		end
	end

	assign o_sync = sync_r;

endmodule

// ===== design/pfs_pin_mux.sv
// Pin function selector for port A pins 4-6, port B pins 1-2, port C pin 2
// and the debug clock pin. Pad levels arrive asynchronous; everything else
// comes from logic on the system clock.
`timescale 1ns/1ps

module pfs_pin_mux (
	input  wire logic                         i_sys_clk,
	input  wire logic                         i_reset,
	// Pad side
	input  wire logic [pfs_pkg::NUM_INS-1:0]  i_pad_in,
	output logic      [pfs_pkg::NUM_PADS-1:0] o_pad_out,
	output logic      [pfs_pkg::NUM_PADS-1:0] o_pad_oe_n,
	output logic                              o_port_c_two_pull_up,
	output logic                              o_debug_clock_pull_down,
	output logic                              o_analog_input_four,
	output logic                              o_analog_input_five,
	// Configuration
	input  wire logic [11:0]                  i_port_a_high_config,
	input  wire logic [11:4]                  i_port_b_low_config,
	input  wire logic [11:8]                  i_port_c_low_config,
	input  wire logic                         i_debug_pin_gpio_en,
	input  wire logic                         i_timer_one_ch3_en,
	input  wire logic                         i_timer_two_ch1_en,
	input  wire logic                         i_timer_two_ch2_en,
	input  wire logic [5:4]                   i_timer_two_remap_options,
	input  wire logic [1:0]                   i_serial_one_mode_select,
	input  wire logic                         i_serial_one_spi_master,
	input  wire logic                         i_core_trace_en,
	input  wire logic                         i_core_trace_sync_four,
	input  wire logic                         i_core_trace_async,
	input  wire logic                         i_packet_trace_port_en,
	input  wire logic                         i_serial_wire_switch,
	// Function sources
	input  wire logic [pfs_pkg::NUM_PADS-1:0] i_gpio_out,
	input  wire logic [pfs_pkg::NUM_PADS-1:0] i_gpio_oe_n,
	input  wire logic                         i_core_trace_bit_two,
	input  wire logic                         i_core_trace_bit_three,
	input  wire logic                         i_packet_trace_frame,
	input  wire logic                         i_packet_trace_serial,
	input  wire logic                         i_timer_one_channel_three,
	input  wire logic                         i_timer_two_channel_one,
	input  wire logic                         i_timer_two_channel_two,
	input  wire logic                         i_serial_one_spi_out_master,
	input  wire logic                         i_serial_one_spi_out_slave,
	input  wire logic                         i_serial_one_uart_transmit,
	input  wire logic                         i_serial_one_twowire_data,
	input  wire logic                         i_serial_one_twowire_clock,
	input  wire logic                         i_jtag_data_output,
	input  wire logic                         i_swo_trace,
	// Function sinks
	output logic      [pfs_pkg::NUM_PADS-1:0] o_gpio_in,
	output logic                              o_timer_one_channel_three,
	output logic                              o_timer_two_channel_two,
	output logic                              o_serial_one_spi_in_master,
	output logic                              o_serial_one_spi_in_slave,
	output logic                              o_serial_one_uart_receive,
	output logic                              o_serial_one_twowire_data,
	output logic                              o_serial_one_twowire_clock,
	output logic                              o_jtag_clock_input,
	output logic                              o_serial_wire_clock,
	output logic                              o_serial_wire_mode,
	output logic                              o_boot_monitor_select,
	output logic                              o_boot_sampled
);
	import pfs_pkg::*;

	logic [NUM_INS-1:0]  pad_s;
	pfs_pad_t            pad_nxt [NUM_PADS];
	pfs_pad_t            pad_r   [NUM_PADS];
	pfs_dbg_t            dbg_r;
	pfs_dbg_t            dbg_nxt;
	logic [1:0]          boot_cnt_r;
	logic                boot_mon_r;
	logic                boot_done_r;
	logic                dclk_pd_r;
	logic [NUM_PADS-1:0] gpio_in_r;
	logic                t1c3_in_r;
	logic                t2c2_in_r;
	logic                spi_in_m_r;
	logic                spi_in_s_r;
	logic                uart_rx_r;
	logic                twi_d_r;
	logic                twi_c_r;
	logic                jtag_clock_input_r;
	logic                swclk_r;
	logic                trace_four;
	logic                trace_off;
	logic                is_spi;
	logic                is_twi;
	logic                jtag_mode;

	// ****************************************
	// Pad input synchronisation
	// ****************************************
	pfs_sync #(
		.WIDTH (NUM_INS)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_reset   (i_reset),
		.i_async   (i_pad_in),
		.o_sync    (pad_s)
	);

	assign trace_four = i_core_trace_en && i_core_trace_sync_four && !i_core_trace_async;
	assign trace_off  = !i_core_trace_en;
	assign is_spi     = i_serial_one_mode_select == SC_SPI;
	assign is_twi     = i_serial_one_mode_select == SC_TWI;
	assign jtag_mode  = dbg_r == PFS_DBG_JTAG;

	// ****************************************
	// Debug mode
	// ****************************************
	// Only a reset returns to JTAG; the switch sequence is decoded upstream
	always_comb begin
		dbg_nxt = dbg_r;
		case (dbg_r)
			PFS_DBG_JTAG: begin
				if (i_serial_wire_switch) begin
					dbg_nxt = PFS_DBG_SWIRE;
				end
			end
			PFS_DBG_SWIRE: begin
				dbg_nxt = PFS_DBG_SWIRE;
			end
			default: begin
				dbg_nxt = PFS_DBG_JTAG;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			dbg_r <= PFS_DBG_JTAG;
		end else begin
			dbg_r <= dbg_nxt;
		end
	end

	// ****************************************
	// Boot select capture
	// ****************************************
	// Level is taken after release, once the synchroniser holds a real sample
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			boot_cnt_r  <= 2'h0;
			boot_mon_r  <= 1'b0;
			boot_done_r <= 1'b0;
		end else if (!boot_done_r) begin
			if (boot_cnt_r == BOOT_WAIT) begin
				boot_mon_r  <= !pad_s[PAD_A5];
				boot_done_r <= 1'b1;
			end else begin
				boot_cnt_r <= boot_cnt_r + 2'h1;
			end
		end
	end

	// ****************************************
	// Output routing
	// ****************************************
	always_comb begin
		for (int i = 0; i < NUM_PADS; i++) begin
			pad_nxt[i]         = PAD_IDLE;
			pad_nxt[i].drive   = i_gpio_out[i];
			pad_nxt[i].oe_n    = i_gpio_oe_n[i];
		end

		if (pfs_is_analog(i_port_a_high_config[3:0])) begin
			pad_nxt[PAD_A4]        = PAD_IDLE;
			pad_nxt[PAD_A4].analog = 1'b1;
		end else if (pfs_is_alt(i_port_a_high_config[3:0]) && trace_four) begin
			pad_nxt[PAD_A4].drive = i_core_trace_bit_two;
			pad_nxt[PAD_A4].oe_n  = 1'b0;
		end else if (pfs_is_alt(i_port_a_high_config[3:0]) && trace_off && i_packet_trace_port_en) begin
			pad_nxt[PAD_A4].drive = i_packet_trace_frame;
			pad_nxt[PAD_A4].oe_n  = 1'b0;
		end

		if (pfs_is_analog(i_port_a_high_config[7:4])) begin
			pad_nxt[PAD_A5]        = PAD_IDLE;
			pad_nxt[PAD_A5].analog = 1'b1;
		end else if (pfs_is_alt(i_port_a_high_config[7:4]) && trace_four) begin
			pad_nxt[PAD_A5].drive = i_core_trace_bit_three;
			pad_nxt[PAD_A5].oe_n  = 1'b0;
		end else if (pfs_is_alt(i_port_a_high_config[7:4]) && trace_off && i_packet_trace_port_en) begin
			pad_nxt[PAD_A5].drive = i_packet_trace_serial;
			pad_nxt[PAD_A5].oe_n  = 1'b0;
		end

		if (pfs_is_alt(i_port_a_high_config[11:8]) && i_timer_one_ch3_en) begin
			pad_nxt[PAD_A6].drive = i_timer_one_channel_three;
			pad_nxt[PAD_A6].oe_n  = 1'b0;
		end

		// Open drain: low is driven, high is released to the pull-up
		if (pfs_is_od(i_port_b_low_config[7:4]) && is_twi) begin
			pad_nxt[PAD_B1].drive = 1'b0;
			pad_nxt[PAD_B1].oe_n  = i_serial_one_twowire_data;
		end else if (pfs_is_alt(i_port_b_low_config[7:4]) && i_timer_two_remap_options[REMAP_CH1]
				&& i_timer_two_ch1_en) begin
			pad_nxt[PAD_B1].drive = i_timer_two_channel_one;
			pad_nxt[PAD_B1].oe_n  = 1'b0;
		end else if (pfs_is_alt(i_port_b_low_config[7:4])
				&& (is_spi || i_serial_one_mode_select == SC_UART)) begin
			pad_nxt[PAD_B1].oe_n = 1'b0;
			if (!is_spi) begin
				pad_nxt[PAD_B1].drive = i_serial_one_uart_transmit;
			end else if (i_serial_one_spi_master) begin
				pad_nxt[PAD_B1].drive = i_serial_one_spi_out_master;
			end else begin
				pad_nxt[PAD_B1].drive = i_serial_one_spi_out_slave;
			end
		end

		if (pfs_is_od(i_port_b_low_config[11:8]) && is_twi
				&& !(i_timer_two_ch2_en && i_timer_two_remap_options[REMAP_CH2])) begin
			pad_nxt[PAD_B2].drive = 1'b0;
			pad_nxt[PAD_B2].oe_n  = i_serial_one_twowire_clock;
		end else if (pfs_is_alt(i_port_b_low_config[11:8]) && i_timer_two_remap_options[REMAP_CH2]
				&& i_timer_two_ch2_en) begin
			pad_nxt[PAD_B2].drive = i_timer_two_channel_two;
			pad_nxt[PAD_B2].oe_n  = 1'b0;
		end

		// Debug use wins over everything unless software frees the pin
		if (!i_debug_pin_gpio_en) begin
			pad_nxt[PAD_C2] = PAD_IDLE;
			if (jtag_mode) begin
				pad_nxt[PAD_C2].drive = i_jtag_data_output;
				pad_nxt[PAD_C2].oe_n  = 1'b0;
			end else if (i_core_trace_en && i_core_trace_async && pfs_is_alt(i_port_c_low_config)) begin
				pad_nxt[PAD_C2].drive   = i_swo_trace;
				pad_nxt[PAD_C2].oe_n    = 1'b0;
				pad_nxt[PAD_C2].pull_up = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < NUM_PADS; i++) begin
				pad_r[i] <= PAD_IDLE;
			end
		end else begin
			for (int i = 0; i < NUM_PADS; i++) begin
				pad_r[i] <= pad_nxt[i];
			end
		end
	end

	generate
		for (genvar g = 0; g < NUM_PADS; g++) begin : g_pad
			assign o_pad_out[g]  = pad_r[g].drive;
			assign o_pad_oe_n[g] = pad_r[g].oe_n;
		end
	endgenerate

	assign o_port_c_two_pull_up = pad_r[PAD_C2].pull_up;
	assign o_analog_input_four  = pad_r[PAD_A4].analog;
	assign o_analog_input_five  = pad_r[PAD_A5].analog;

	// ****************************************
	// Input routing
	// ****************************************
	// Unselected sinks rest at their idle level so peripherals see no edges; the timer one channel three sink always follows pin six
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			gpio_in_r  <= '0;
			t1c3_in_r  <= 1'b0;
			t2c2_in_r  <= 1'b0;
			spi_in_m_r <= 1'b0;
			spi_in_s_r <= 1'b0;
			uart_rx_r  <= 1'b1;
			twi_d_r    <= 1'b1;
			twi_c_r    <= 1'b1;
		end else begin
			gpio_in_r  <= pad_s[NUM_PADS-1:0];
			t1c3_in_r  <= pad_s[PAD_A6];
			t2c2_in_r  <= i_timer_two_remap_options[REMAP_CH2] ? pad_s[PAD_B2] : 1'b0;
			spi_in_m_r <= (is_spi && i_serial_one_spi_master) ? pad_s[PAD_B2] : 1'b0;
			spi_in_s_r <= (is_spi && !i_serial_one_spi_master) ? pad_s[PAD_B2] : 1'b0;
			uart_rx_r  <= (i_serial_one_mode_select == SC_UART) ? pad_s[PAD_B2] : 1'b1;
			twi_d_r    <= is_twi ? pad_s[PAD_B1] : 1'b1;
			twi_c_r    <= is_twi ? pad_s[PAD_B2] : 1'b1;
		end
	end

	// ****************************************
	// Debug clock pin
	// ****************************************
	// Pull-down holds the clock quiet when no debugger is attached
	always_ff @(posedge i_sys_clk or posedge i_reset) begin
		if (i_reset) begin
			dclk_pd_r <= 1'b1;
			jtag_clock_input_r    <= 1'b0;
			swclk_r   <= 1'b0;
		end else begin
			dclk_pd_r <= 1'b1;
			jtag_clock_input_r    <= jtag_mode ? pad_s[PAD_DCLK] : 1'b0;
			swclk_r   <= jtag_mode ? 1'b0 : pad_s[PAD_DCLK];
		end
	end

	assign o_gpio_in                  = gpio_in_r;
	assign o_timer_one_channel_three  = t1c3_in_r;
	assign o_timer_two_channel_two    = t2c2_in_r;
	assign o_serial_one_spi_in_master = spi_in_m_r;
	assign o_serial_one_spi_in_slave  = spi_in_s_r;
	assign o_serial_one_uart_receive  = uart_rx_r;
	assign o_serial_one_twowire_data  = twi_d_r;
	assign o_serial_one_twowire_clock = twi_c_r;
	assign o_jtag_clock_input         = jtag_clock_input_r;
	assign o_serial_wire_clock        = swclk_r;
	assign o_serial_wire_mode         = dbg_r == PFS_DBG_SWIRE;
	assign o_debug_clock_pull_down    = dclk_pd_r;
	assign o_boot_monitor_select      = boot_mon_r;
	assign o_boot_sampled             = boot_done_r;

	// ****************************************
	// Checks
	// ****************************************
	analog_four_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		pfs_is_analog(i_port_a_high_config[3:0]) |=> o_analog_input_four && o_pad_oe_n[PAD_A4])
		else $error("pin four analog path not connected");

	frame_out_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		pfs_is_alt(i_port_a_high_config[3:0]) && trace_off && i_packet_trace_port_en
		|=> !o_pad_oe_n[PAD_A4] && o_pad_out[PAD_A4] == $past(i_packet_trace_frame))
		else $error("packet trace frame not on pin four");

	trace_three_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		pfs_is_alt(i_port_a_high_config[7:4]) && trace_four
		|=> o_pad_out[PAD_A5] == $past(i_core_trace_bit_three))
		else $error("trace bit three not on pin five");

	boot_capture_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$rose(o_boot_sampled) |-> o_boot_monitor_select == !$past(pad_s[PAD_A5]))
		else $error("boot select captured wrongly");

	timer_one_in_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		##1 o_timer_one_channel_three == $past(pad_s[PAD_A6]))
		else $error("timer one input not from pin six");

	twowire_data_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		pfs_is_od(i_port_b_low_config[7:4]) && is_twi
		|=> !o_pad_out[PAD_B1] && o_pad_oe_n[PAD_B1] == $past(i_serial_one_twowire_data))
		else $error("two-wire data not open drain");

	timer_two_ch1_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		pfs_is_alt(i_port_b_low_config[7:4]) && i_timer_two_remap_options[REMAP_CH1] && i_timer_two_ch1_en
		|=> !o_pad_oe_n[PAD_B1] && o_pad_out[PAD_B1] == $past(i_timer_two_channel_one))
		else $error("timer two channel one not on pin one");

	uart_rx_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		i_serial_one_mode_select == SC_UART |=> o_serial_one_uart_receive == $past(pad_s[PAD_B2]))
		else $error("uart receive not from pin two");

	c2_release_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		i_debug_pin_gpio_en |=> o_pad_oe_n[PAD_C2] == $past(i_gpio_oe_n[PAD_C2]))
		else $error("port c pin two not under gpio control");

	jtag_out_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		jtag_mode && !i_debug_pin_gpio_en |=> !o_pad_oe_n[PAD_C2] && o_pad_out[PAD_C2] == $past(i_jtag_data_output))
		else $error("jtag data out missing");

	jtag_reset_a: assert property (@(posedge i_sys_clk) disable iff (i_reset)
		$fell(o_serial_wire_mode) |-> 1'b0)
		else $error("serial wire mode left without reset");

endmodule

// ===== bench/pfs_far_side.sv
// Far-side pad model: board pulls and external parts driving the pads.
// Assumes the bench drives external levels off the clock edge.
`timescale 1ns/1ps

module pfs_far_side (
	input  wire logic       i_sys_clk,
	input  wire logic [5:0] i_pad_out,
	input  wire logic [5:0] i_pad_oe_n,
	input  wire logic       i_pull_up,
	input  wire logic       i_pull_down,
	input  wire logic [6:0] i_ext_en,
	input  wire logic [6:0] i_ext_val,
	output logic      [6:0] o_level
);
	logic wobble_r = 1'h0;

	// Unpulled idle pads wander so a stale level never passes for a match
	always_ff @(posedge i_sys_clk) begin
		wobble_r <= !wobble_r;
	end

	always_comb begin
		for (int k = 0; k < 6; k++) begin
			o_level[k] = i_ext_en[k] ? i_ext_val[k] : wobble_r;
			if (!i_pad_oe_n[k]) begin
				o_level[k] = i_pad_out[k];
			end
		end
		// Board pull-ups on the two-wire lines, then the port C pin two pull-up and the debug clock pull-down
		if (i_pad_oe_n[3] && !i_ext_en[3]) begin
			o_level[3] = 1'h1;
		end
		if (i_pad_oe_n[4] && !i_ext_en[4]) begin
			o_level[4] = 1'h1;
		end
		if (i_pad_oe_n[5] && !i_ext_en[5] && i_pull_up) begin
			o_level[5] = 1'h1;
		end
		o_level[6] = i_ext_en[6] ? i_ext_val[6] : (i_pull_down ? 1'h0 : wobble_r);
	end
endmodule

// ===== bench/pin_function_select_tb_top.sv
// Self-checking bench for the pin function selector.
// Assumes inputs change on the falling edge; pad outputs lag their selects by one clock.
`timescale 1ns/1ps

module pin_function_select_tb_top;
	import pfs_pkg::*;
	logic i_sys_clk = 1'h0, i_reset = 1'h1;
	logic [6:0] i_pad_in, ext_en = 7'h02, ext_val = 7'h00;
	logic [5:0] o_pad_out, o_pad_oe_n, o_gpio_in, i_gpio_out = 6'h00, i_gpio_oe_n = 6'h3f;
	logic [11:0] i_port_a_high_config = 12'h111;
	logic [11:4] i_port_b_low_config = 8'h11;
	logic [11:8] i_port_c_low_config = 4'h1;
	logic [5:4] i_timer_two_remap_options = 2'h0;
	logic [1:0] i_serial_one_mode_select = 2'h0;
	logic i_debug_pin_gpio_en = 1'h0, i_timer_one_ch3_en = 1'h0, i_timer_two_ch1_en = 1'h0;
	logic i_timer_two_ch2_en = 1'h0, i_serial_one_spi_master = 1'h0, i_core_trace_en = 1'h0;
	logic i_core_trace_sync_four = 1'h0, i_core_trace_async = 1'h0, i_packet_trace_port_en = 1'h0;
	logic i_serial_wire_switch = 1'h0, i_core_trace_bit_two = 1'h0, i_core_trace_bit_three = 1'h0;
	logic i_packet_trace_frame = 1'h0, i_packet_trace_serial = 1'h0, i_timer_one_channel_three = 1'h0;
	logic i_timer_two_channel_one = 1'h0, i_timer_two_channel_two = 1'h0, i_swo_trace = 1'h0;
	logic i_serial_one_spi_out_master = 1'h0, i_serial_one_spi_out_slave = 1'h0;
	logic i_serial_one_uart_transmit = 1'h0, i_serial_one_twowire_data = 1'h1;
	logic i_serial_one_twowire_clock = 1'h1, i_jtag_data_output = 1'h0;
	logic o_port_c_two_pull_up, o_debug_clock_pull_down, o_analog_input_four, o_analog_input_five;
	logic o_timer_one_channel_three, o_timer_two_channel_two, o_serial_one_spi_in_master;
	logic o_serial_one_spi_in_slave, o_serial_one_uart_receive, o_serial_one_twowire_data;
	logic o_serial_one_twowire_clock, o_jtag_clock_input, o_serial_wire_clock, o_serial_wire_mode;
	logic o_boot_monitor_select, o_boot_sampled;
	int error_cnt = 0, samples_checked = 0;

	always #2.5 i_sys_clk = !i_sys_clk;

	pfs_pin_mux u_pfs_pin_mux (.*);
	pfs_far_side u_pfs_far_side (.i_sys_clk, .i_pad_out(o_pad_out), .i_pad_oe_n(o_pad_oe_n),
		.i_pull_up(o_port_c_two_pull_up), .i_pull_down(o_debug_clock_pull_down), .i_ext_en(ext_en),
		.i_ext_val(ext_val), .o_level(i_pad_in));

	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge i_sys_clk);
	endtask

	task automatic print_verdict();
		$display("mismatches=%0d comparisons=%0d", error_cnt, samples_checked);
		if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// ****************************************
	// Scenarios
	// ****************************************
	task automatic t_gpio_and_analog();
		i_gpio_out = 6'h2a;
		i_gpio_oe_n = 6'h00;
		i_debug_pin_gpio_en = 1'h1;
		tick(1);
		chk(o_pad_out, 6'h2a);
		chk(o_pad_oe_n, 6'h00);
		i_debug_pin_gpio_en = 1'h0;
		tick(1);
		chk({o_pad_out[5], o_pad_oe_n[5]}, 2'h0);
		i_port_a_high_config = 12'h100;
		tick(1);
		chk({o_analog_input_five, o_analog_input_four, o_pad_oe_n[1:0]}, 4'hf);
	endtask

	task automatic t_trace();
		i_port_a_high_config = 12'h199;
		i_packet_trace_port_en = 1'h1;
		i_packet_trace_frame = 1'h1;
		tick(1);
		chk({o_pad_out[1:0], o_pad_oe_n[1:0]}, 4'h4);
		i_packet_trace_frame = 1'h0;
		i_packet_trace_serial = 1'h1;
		tick(1);
		chk(o_pad_out[1:0], 2'h2);
		{i_core_trace_en, i_core_trace_sync_four, i_core_trace_bit_two} = 3'h7;
		i_packet_trace_serial = 1'h0;
		tick(1);
		chk(o_pad_out[1:0], 2'h1);
		i_core_trace_bit_three = 1'h1;
		tick(1);
		chk(o_pad_out[1:0], 2'h3);
	endtask

	task automatic t_timer_one();
		i_port_a_high_config = 12'h911;
		{i_timer_one_ch3_en, i_timer_one_channel_three} = 2'h3;
		tick(1);
		chk({o_pad_out[2], o_pad_oe_n[2]}, 2'h2);
		tick(3);
		chk(o_timer_one_channel_three, 1'h1);
	endtask

	task automatic t_port_b_one();
		logic [1:0] md [3] = '{SC_UART, SC_SPI, SC_SPI};
		i_port_b_low_config = 8'h19;
		for (int i = 0; i < 3; i++) begin
			i_serial_one_mode_select = md[i];
			i_serial_one_spi_master = (i == 1);
			{i_serial_one_spi_out_slave, i_serial_one_spi_out_master, i_serial_one_uart_transmit} = 3'h1 << i;
			tick(1);
			chk({o_pad_out[3], o_pad_oe_n[3]}, 2'h2);
		end
		{i_timer_two_remap_options[4], i_timer_two_ch1_en} = 2'h3;
		tick(1);
		chk(o_pad_out[3], 1'h0);
		i_timer_two_ch1_en = 1'h0;
		tick(1);
		chk(o_pad_out[3], 1'h1);
	endtask

	task automatic t_two_wire();
		i_serial_one_mode_select = SC_TWI;
		i_port_b_low_config = 8'hdd;
		i_serial_one_twowire_data = 1'h0;
		tick(1);
		chk({o_pad_oe_n[4:3], o_pad_out[4:3]}, 4'h8);
		tick(3);
		chk({o_serial_one_twowire_data, o_serial_one_twowire_clock}, 2'h1);
		{i_timer_two_remap_options[5], i_timer_two_ch2_en, i_timer_two_channel_two} = 3'h7;
		i_port_b_low_config = 8'h9d;
		tick(1);
		chk({o_pad_out[4], o_pad_oe_n[4]}, 2'h2);
		tick(3);
		chk(o_timer_two_channel_two, 1'h1);
	endtask

	task automatic t_receive();
		{i_timer_two_remap_options, i_timer_two_ch2_en} = 3'h0;
		i_port_b_low_config = 8'h11;
		i_serial_one_mode_select = SC_UART;
		// Release the gpio drivers so the external part owns the receive pad
		i_gpio_oe_n = 6'h3f;
		{ext_en[4], ext_val[4]} = 2'h2;
		// One edge for the pad to release, then two sync stages and the sink flop
		tick(4);
		chk(o_serial_one_uart_receive, 1'h0);
		chk(o_gpio_in[4], 1'h0);
		i_serial_one_mode_select = SC_SPI;
		i_serial_one_spi_master = 1'h1;
		ext_val[4] = 1'h1;
		tick(3);
		chk({o_serial_one_spi_in_master, o_serial_one_spi_in_slave, o_serial_one_uart_receive}, 3'h5);
		i_serial_one_spi_master = 1'h0;
		tick(3);
		chk({o_serial_one_spi_in_master, o_serial_one_spi_in_slave}, 2'h1);
	endtask

	task automatic t_debug();
		{ext_en[6], ext_val[6]} = 2'h3;
		tick(3);
		chk({o_jtag_clock_input, o_serial_wire_clock}, 2'h2);
		i_port_c_low_config = 4'h9;
		{i_core_trace_sync_four, i_core_trace_async, i_swo_trace} = 3'h3;
		// Debugger has sent the switch sequence
		i_serial_wire_switch = 1'h1;
		tick(1);
		i_serial_wire_switch = 1'h0;
		chk(o_serial_wire_mode, 1'h1);
		tick(1);
		chk({o_pad_out[5], o_pad_oe_n[5], o_port_c_two_pull_up}, 3'h5);
		tick(2);
		chk({o_jtag_clock_input, o_serial_wire_clock, o_debug_clock_pull_down}, 3'h3);
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		tick(3);
		chk({o_pad_oe_n, o_debug_clock_pull_down, o_serial_wire_mode}, 8'hfe);
		i_reset = 1'h0;
		tick(3);
		chk({o_boot_sampled, o_boot_monitor_select}, 2'h3);
		ext_en = 7'h00;
		t_gpio_and_analog();
		t_trace();
		t_timer_one();
		t_port_b_one();
		t_two_wire();
		t_receive();
		t_debug();
		print_verdict();
	end

	initial begin
		repeat (5000) @(posedge i_sys_clk);
		error_cnt++;
		print_verdict();
	end
endmodule
